// ===== hw/sgio_map.svh
// Register offsets, indexed register numbers, field positions and reset values of the sense and I/O port.
`ifndef SGIO_MAP_SVH
`define SGIO_MAP_SVH

// ----------------------------------------------------------------------------
// Bus byte offsets
// ----------------------------------------------------------------------------
`define SGIO_OFS_INDEX     4'h0
`define SGIO_OFS_DATA      4'h4
`define SGIO_OFS_IRQ_STAT  4'h8
`define SGIO_OFS_IRQ_MASK  4'hC

// ----------------------------------------------------------------------------
// Indexed register numbers
// ----------------------------------------------------------------------------
`define SGIO_IDX_STATUS    7'h02
`define SGIO_IDX_SENSE_CTL 7'h03
`define SGIO_IDX_COMMAND   7'h07
`define SGIO_IDX_MISC_DIR  7'h08
`define SGIO_IDX_MISC_POL  7'h09
`define SGIO_IDX_MISC_SENS 7'h0A
`define SGIO_IDX_MISC_OUT  7'h0B
`define SGIO_IDX_S2_DELAY  7'h0C
`define SGIO_IDX_LAST_RO   7'h02

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SGIO_CTL_S1_STOP   0
`define SGIO_CTL_S2_STOP   1
`define SGIO_CTL_S1_POL    2
`define SGIO_CTL_S2_POL    3
`define SGIO_CTL_SCANNING  4
`define SGIO_CTL_S1_SENS   5
`define SGIO_CTL_S2_SENS   6
`define SGIO_CMD_SOFT_RST  7
`define SGIO_STAT_S1       0
`define SGIO_STAT_S2       1
`define SGIO_STAT_MISC_LO  2
`define SGIO_IRQ_S1        0
`define SGIO_IRQ_S2        1
`define SGIO_IRQ_MISC      2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SGIO_RST_MISC_DIR  6'h38
`define SGIO_RST_MISC_POL  6'h00
`define SGIO_RST_MISC_SENS 6'h07
`define SGIO_RST_MISC_OUT  6'h18
`define SGIO_RST_SENSE_CTL 8'h00
`define SGIO_RST_S2_DELAY  8'h00
`define SGIO_RST_IRQ_MASK  3'h0

`endif

// ===== hw/sgio_pkg.sv
// Types shared by the sense and I/O port files.
package sgio_pkg;

  // Configuration of the six general pins, one bit per pin.
  typedef struct packed {
    logic [5:0] dir;
    logic [5:0] pol;
    logic [5:0] sens;
    logic [5:0] out;
  } misc_cfg_type;

  // Motion state kept behind the scanning bit.
  typedef enum logic [3:0] {
    MOVE_IDLE = 4'h1,
    MOVE_SCAN = 4'h2,
    MOVE_FWD  = 4'h4,
    MOVE_REV  = 4'h8
  } move_type;

  // AXI4-Lite response codes.
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_DECERR = 2'h3
  } resp_type;

endpackage

// ===== hw/sgio_capture.sv
// Input synchroniser, polarity, level and edge capture for a group of sense pins.
`timescale 1ns/1ps
module sgio_capture #(
  parameter int W = 6
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Pins and per-pin setup.
  input  wire logic [W-1:0] pin,
  input  wire logic [W-1:0] pol,
  input  wire logic [W-1:0] sens,
  // Status read strobe.
  input  wire logic         clear,
  // Results.
  output logic      [W-1:0] stat,
  output logic      [W-1:0] rise
);

  logic [W-1:0] sync_a;
  logic [W-1:0] sync_b;
  logic [W-1:0] prev;
  logic [W-1:0] held;
  logic [W-1:0] level;

  // Two-stage synchroniser; only the second stage is looked at.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  // Polarity: a set bit makes a high pin read true.
  assign level = ~(sync_b ^ pol);

  // Previous true state for false-to-true detection.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= '1; // Starts true so the release of reset never looks like an edge.
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;

  // Edge capture; a new edge wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      held <= '0;
    end else begin
      held <= rise | (held & ~{W{clear}});
    end
  end

  // Level mode shows the live state, edge mode the captured one.
  assign stat = (sens & held) | (~sens & level);

endmodule // sgio_capture

// ===== hw/sgio_port.sv
// Sense inputs and general I/O pins with indexed register access over AXI4-Lite.
//
// Summary of operation
// - Two sense inputs, six direction-configurable pins.
// - Direction bit 0 input, 1 output.
// - Polarity 1 makes high read true.
// - Level mode shows live adjusted state; the sense two status bit sets only after its line delay.
// - Edge mode latches any false-to-true change.
// - Status read clears captured edge bits.
// - Sense one edge can stop any motion.
// - Sense two stops after programmable line count.
// - Sense two never stops reverse motion.
// - Output pin drives its written output bit.
// - Hard reset and suspend restore pin defaults.
// - Soft reset keeps pin setup and outputs.
// - Pins one-three default to falling-edge inputs.
// - Pins four-five drive high, six low.
// - Written index persists for later accesses.
// - Index three bit four is read-only.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sgio_map.svh"
module sgio_port #(
  parameter int LINE_W = 8
) (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RST,
  // Power state and line timing.
  input  wire logic        SUSPEND,
  input  wire logic        LINE_TICK,
  // Pins.
  input  wire logic        SENSE_IN1,
  input  wire logic        SENSE_IN2,
  input  wire logic [5:0]  MISC_IN,
  output logic      [5:0]  MISC_OUT,
  output logic      [5:0]  MISC_OE,
  // Motion state and interrupt.
  output logic             SCANNING,
  output logic             IRQ,
  // AXI4-Lite write address and data.
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [3:0]  AWADDR,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  // AXI4-Lite write response.
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic      [1:0]  BRESP,
  // AXI4-Lite read.
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [3:0]  ARADDR,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic      [31:0] RDATA,
  output logic      [1:0]  RRESP
);

  // --------------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------------
  if (LINE_W < 1 || LINE_W > 8) begin : g_bad_width
    $error("LINE_W must lie between 1 and 8.");
  end

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  sgio_pkg::misc_cfg_type misc;
  sgio_pkg::move_type     move;
  logic [6:0]             index;
  logic [7:0]             sense_ctl;
  logic [LINE_W-1:0]      s2_delay;
  logic [LINE_W-1:0]      s2_count;
  logic                   s2_armed;
  logic                   s2_hit;
  logic [2:0]             irq_stat;
  logic [2:0]             irq_mask;
  logic                   aw_held;
  logic                   w_held;
  logic [3:0]             aw_addr;
  logic [31:0]            w_data;
  logic                   w_lane0;
  logic                   wstrb_lane;
  logic                   wr_go;
  logic                   rd_go;
  logic                   idx_wr;
  logic                   idx_rd;
  logic                   stat_rd;
  logic                   irq_rd;
  logic [7:0]             wbyte;
  logic [7:0]             idx_data;
  logic [1:0]             s_stat;
  logic [1:0]             s_rise;
  logic [5:0]             m_stat;
  logic [5:0]             m_rise;
  logic                   s1_stop;
  logic                   s2_done;
  logic                   s2_stop;
  logic                   soft_rst;
  logic [2:0]             next_irq;

  // Match of a bus offset against one register offset.
  function automatic logic is_ofs(input logic [3:0] a, input logic [3:0] ofs);
    is_ofs = (a == ofs);
  endfunction

  // Offsets that answer OKAY.
  function automatic logic mapped(input logic [3:0] a);
    mapped = is_ofs(a, `SGIO_OFS_INDEX) || is_ofs(a, `SGIO_OFS_DATA) ||
             is_ofs(a, `SGIO_OFS_IRQ_STAT) || is_ofs(a, `SGIO_OFS_IRQ_MASK);
  endfunction

  // --------------------------------------------------------------------------
  // Input capture
  // --------------------------------------------------------------------------
  sgio_capture #(
    .W (2)
  ) u_sense (
    .clk   (CLK),
    .rst   (RST),
    .pin   ({SENSE_IN2, SENSE_IN1}),
    .pol   ({sense_ctl[`SGIO_CTL_S2_POL], sense_ctl[`SGIO_CTL_S1_POL]}),
    .sens  ({sense_ctl[`SGIO_CTL_S2_SENS], sense_ctl[`SGIO_CTL_S1_SENS]}),
    .clear (stat_rd),
    .stat  (s_stat),
    .rise  (s_rise)
  );

  sgio_capture #(
    .W (6)
  ) u_misc (
    .clk   (CLK),
    .rst   (RST),
    .pin   (MISC_IN),
    .pol   (misc.pol),
    .sens  (misc.sens),
    .clear (stat_rd),
    .stat  (m_stat),
    .rise  (m_rise)
  );

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  assign wr_go    = aw_held && w_held && !BVALID;
  assign rd_go    = ARVALID && ARREADY;
  assign w_lane0  = wstrb_lane; // Lane zero carries the byte; without it a data write is dropped.
  assign wbyte    = w_data[7:0];
  assign idx_wr   = wr_go && is_ofs(aw_addr, `SGIO_OFS_DATA) && w_lane0;
  assign idx_rd   = rd_go && is_ofs(ARADDR, `SGIO_OFS_DATA);
  assign stat_rd  = idx_rd && (index == `SGIO_IDX_STATUS);
  assign irq_rd   = rd_go && is_ofs(ARADDR, `SGIO_OFS_IRQ_STAT);
  assign soft_rst = idx_wr && (index == `SGIO_IDX_COMMAND) && wbyte[`SGIO_CMD_SOFT_RST];

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  // Address and data are taken in either order and held until the write.
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held    <= 1'b0;
      w_held     <= 1'b0;
      aw_addr    <= 4'h0;
      w_data     <= 32'h0000_0000;
      wstrb_lane <= 1'b0;
      AWREADY    <= 1'b1;
      WREADY     <= 1'b1;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
        AWREADY <= 1'b0;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_held     <= 1'b1;
        w_data     <= WDATA;
        wstrb_lane <= WSTRB[0];
        WREADY     <= 1'b0;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
      if (BVALID && BREADY) begin
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  // Write response follows both halves.
  always_ff @(posedge CLK) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP  <= sgio_pkg::RESP_OKAY;
    end else if (wr_go) begin
      BVALID <= 1'b1;
      BRESP  <= mapped(aw_addr) ? sgio_pkg::RESP_OKAY : sgio_pkg::RESP_DECERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  // Indexed register read mux.
  always_comb begin
    idx_data = 8'h00;
    unique case (index)
      `SGIO_IDX_STATUS:    idx_data = {m_stat, s2_hit, s_stat[0]};
      `SGIO_IDX_SENSE_CTL: idx_data = sense_ctl;
      `SGIO_IDX_COMMAND:   idx_data = {4'h0, move};
      `SGIO_IDX_MISC_DIR:  idx_data = {2'h0, misc.dir};
      `SGIO_IDX_MISC_POL:  idx_data = {2'h0, misc.pol};
      `SGIO_IDX_MISC_SENS: idx_data = {2'h0, misc.sens};
      `SGIO_IDX_MISC_OUT:  idx_data = {2'h0, misc.out};
      `SGIO_IDX_S2_DELAY:  idx_data = 8'(s2_delay);
      default:             idx_data = 8'h00;
    endcase
  end

  // One read at a time; data stands until taken.
  always_ff @(posedge CLK) begin
    if (RST) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= sgio_pkg::RESP_OKAY;
    end else if (rd_go) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RRESP   <= mapped(ARADDR) ? sgio_pkg::RESP_OKAY : sgio_pkg::RESP_DECERR;
      unique case (ARADDR)
        `SGIO_OFS_INDEX:    RDATA <= {25'h0, index};
        `SGIO_OFS_DATA:     RDATA <= {24'h0, idx_data};
        `SGIO_OFS_IRQ_STAT: RDATA <= {29'h0, irq_stat};
        `SGIO_OFS_IRQ_MASK: RDATA <= {29'h0, irq_mask};
        default:            RDATA <= 32'h0000_0000;
      endcase
    end else if (RVALID && RREADY) begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Index and plain registers
  // --------------------------------------------------------------------------
  // The index stays until rewritten.
  always_ff @(posedge CLK) begin
    if (RST) begin
      index <= 7'h00;
    end else if (wr_go && is_ofs(aw_addr, `SGIO_OFS_INDEX) && wstrb_lane) begin
      index <= w_data[6:0];
    end
  end

  // Sense control; the scanning bit is not stored here and writes skip it.
  always_ff @(posedge CLK) begin
    if (RST) begin
      sense_ctl <= `SGIO_RST_SENSE_CTL;
    end else if (idx_wr && index == `SGIO_IDX_SENSE_CTL) begin
      sense_ctl <= wbyte & ~(8'h01 << `SGIO_CTL_SCANNING);
    end
  end

  // Sense two line delay.
  always_ff @(posedge CLK) begin
    if (RST) begin
      s2_delay <= LINE_W'(`SGIO_RST_S2_DELAY);
    end else if (idx_wr && index == `SGIO_IDX_S2_DELAY) begin
      s2_delay <= wbyte[LINE_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // General pin configuration
  // --------------------------------------------------------------------------
  // Defaults return on hard reset and suspend, never on soft reset.
  always_ff @(posedge CLK) begin
    if (RST || SUSPEND) begin
      misc.dir  <= `SGIO_RST_MISC_DIR;
      misc.pol  <= `SGIO_RST_MISC_POL;
      misc.sens <= `SGIO_RST_MISC_SENS;
      misc.out  <= `SGIO_RST_MISC_OUT;
    end else if (idx_wr) begin
      unique case (index)
        `SGIO_IDX_MISC_DIR:  misc.dir  <= wbyte[5:0];
        `SGIO_IDX_MISC_POL:  misc.pol  <= wbyte[5:0];
        `SGIO_IDX_MISC_SENS: misc.sens <= wbyte[5:0];
        `SGIO_IDX_MISC_OUT:  misc.out  <= wbyte[5:0];
        default:             misc      <= misc;
      endcase
    end
  end

  // Pin drivers follow the configuration registers.
  always_ff @(posedge CLK) begin
    if (RST) begin
      MISC_OE  <= `SGIO_RST_MISC_DIR;
      MISC_OUT <= `SGIO_RST_MISC_OUT;
    end else begin
      MISC_OE  <= misc.dir;
      MISC_OUT <= misc.out & misc.dir;
    end
  end

  // --------------------------------------------------------------------------
  // Sense two line delay
  // --------------------------------------------------------------------------
  // Counts lines after a false-to-true change, then raises its status.
  always_ff @(posedge CLK) begin
    if (RST || soft_rst) begin
      s2_armed <= 1'b0;
      s2_count <= '0;
    end else if (s_rise[1]) begin
      s2_armed <= 1'b1;
      s2_count <= '0;
    end else if (s2_armed && (s2_count == s2_delay)) begin
      s2_armed <= 1'b0;
    end else if (s2_armed && LINE_TICK) begin
      s2_count <= s2_count + LINE_W'(1);
    end
  end

  assign s2_done = s2_armed && !s_rise[1] && (s2_count == s2_delay);

  // Delayed sense two status; set wins over the clearing read.
  always_ff @(posedge CLK) begin
    if (RST) begin
      s2_hit <= 1'b0;
    end else if (s2_done) begin
      s2_hit <= 1'b1;
    end else if (sense_ctl[`SGIO_CTL_S2_SENS] ? stat_rd : !s_stat[1]) begin
      s2_hit <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Motion state and scanning bit
  // --------------------------------------------------------------------------
  assign s1_stop = sense_ctl[`SGIO_CTL_S1_STOP] && s_rise[0];
  assign s2_stop = sense_ctl[`SGIO_CTL_S2_STOP] && s2_done &&
                   (move != sgio_pkg::MOVE_REV);

  // Commands start motion; sense stops and soft reset return to idle.
  always_ff @(posedge CLK) begin
    if (RST) begin
      move <= sgio_pkg::MOVE_IDLE;
    end else if (soft_rst || s1_stop || s2_stop) begin
      move <= sgio_pkg::MOVE_IDLE;
    end else if (idx_wr && index == `SGIO_IDX_COMMAND) begin
      unique case (wbyte[1:0])
        2'h1:    move <= sgio_pkg::MOVE_SCAN;
        2'h2:    move <= sgio_pkg::MOVE_FWD;
        2'h3:    move <= sgio_pkg::MOVE_REV;
        default: move <= sgio_pkg::MOVE_IDLE;
      endcase
    end
  end

  // Scanning output is high in every moving state.
  always_ff @(posedge CLK) begin
    if (RST) begin
      SCANNING <= 1'b0;
    end else begin
      SCANNING <= (move != sgio_pkg::MOVE_IDLE);
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  assign next_irq = {|m_rise, s2_done, s_rise[0]};

  // Sticky events cleared by reading; a new event wins over the read.
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= next_irq | (irq_rd ? 3'h0 : irq_stat);
    end
  end

  // Mask register.
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_mask <= `SGIO_RST_IRQ_MASK;
    end else if (wr_go && is_ofs(aw_addr, `SGIO_OFS_IRQ_MASK) && wstrb_lane) begin
      irq_mask <= w_data[2:0];
    end
  end

  // Level interrupt output.
  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat & irq_mask);
    end
  end

endmodule // sgio_port

// ===== tb/sgio_port_checker.sv
// Concurrent checks on the ports of the sense and I/O port.
`timescale 1ns/1ps
module sgio_port_checker #(
  parameter int LINE_W = 8
) (
  // Clock and reset.
  input wire logic        CLK,
  input wire logic        RST,
  // Power state, pins and motion.
  input wire logic        SUSPEND,
  input wire logic [5:0]  MISC_OUT,
  input wire logic [5:0]  MISC_OE,
  input wire logic        SCANNING,
  input wire logic        IRQ,
  // Register bus.
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // ---------------------------------------------------------------
  // Steps of a suspend and of a write.
  // ---------------------------------------------------------------
  sequence sus_held;
    SUSPEND ##1 SUSPEND;
  endsequence
  sequence wr_both;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  a_reset_pins: assert property ($fell(RST) |-> MISC_OE == 6'h38 && MISC_OUT == 6'h18 && !SCANNING && !IRQ)
    else $error("pins not at defaults after reset");
  a_suspend_pins: assert property (sus_held |=> MISC_OE == 6'h38 && MISC_OUT == 6'h18)
    else $error("pins not at defaults in suspend");
  a_input_quiet: assert property ((MISC_OUT & ~MISC_OE) == 6'h00)
    else $error("input pin shows a drive level");
  a_write_answer: assert property (wr_both |-> ##[1:2] BVALID)
    else $error("write response late");
  a_aw_closed: assert property (AWVALID && AWREADY |=> !AWREADY until (BVALID && BREADY))
    else $error("write address reopened early");
  a_b_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read answer late");
  a_r_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read data dropped");
endmodule // sgio_port_checker

bind sgio_port sgio_port_checker #(.LINE_W(LINE_W)) chk (.CLK, .RST, .SUSPEND, .MISC_OUT, .MISC_OE, .SCANNING, .IRQ,
  .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .RVALID, .RREADY, .RDATA, .RRESP);

// ===== tb/sgio_sensors.sv
// Model of the sensors, buttons and lamps wired to the pins.
`timescale 1ns/1ps
module sgio_sensors (
  // Requested sensor and button levels.
  input  wire logic       s1,
  input  wire logic       s2,
  input  wire logic [5:0] btn,
  // Pin drive from the port.
  input  wire logic [5:0] misc_out,
  input  wire logic [5:0] misc_oe,
  // Levels seen by the port.
  output logic            sense1,
  output logic            sense2,
  output logic      [5:0] misc_in
);
  // A driven pin shows the port's level; a released one shows the button.
  assign misc_in = (misc_oe & misc_out) | (~misc_oe & btn);
  assign sense1  = s1;
  assign sense2  = s2;
endmodule // sgio_sensors

// ===== tb/sgio_port_bench.sv
// Self-checking bench for the sense and I/O port.
`timescale 1ns/1ps
module sgio_port_bench;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
    logic [1:0]  r;
  } note_type;
  logic        CLK = 1'b0;
  logic        RST, SUSPEND, LINE_TICK, s1, s2, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [3:0]  AWADDR, ARADDR;
  logic [31:0] WDATA;
  logic [5:0]  btn, r;
  wire logic   SENSE_IN1, SENSE_IN2, AWREADY, WREADY, BVALID, ARREADY, RVALID, SCANNING, IRQ;
  wire logic [5:0]  MISC_IN, MISC_OUT, MISC_OE;
  wire logic [1:0]  BRESP, RRESP;
  wire logic [31:0] RDATA;
  int          failures = 0;
  int          tests_run = 0;
  note_type    notes[$];
  logic [7:0]  didx[4] = '{8'h08, 8'h09, 8'h0A, 8'h0B};
  logic [7:0]  dval[4] = '{8'h38, 8'h00, 8'h07, 8'h18};

  // ---------------------------------------------------------------
  // Clock, design and sensors.
  // ---------------------------------------------------------------
  always #4 CLK = ~CLK;
  sgio_port #(.LINE_W(8)) dut (.CLK, .RST, .SUSPEND, .LINE_TICK, .SENSE_IN1, .SENSE_IN2, .MISC_IN, .MISC_OUT,
    .MISC_OE, .SCANNING, .IRQ, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB(4'hF), .BVALID,
    .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP);
  sgio_sensors sens (.s1, .s2, .btn, .misc_out(MISC_OUT), .misc_oe(MISC_OE), .sense1(SENSE_IN1),
    .sense2(SENSE_IN2), .misc_in(MISC_IN));

  // ---------------------------------------------------------------
  // Compare, bus and closing tasks.
  // ---------------------------------------------------------------
  task automatic cmp_bus(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_pin(input string n, input logic [5:0] e, input logic [5:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      n++;
    end while (!BVALID && n < 100);
    BREADY <= 1'b0;
    if (n >= 100) failures++;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] rs);
    int n;
    n = 0;
    notes.push_back('{e, m, rs});
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      n++;
    end while (!RVALID && n < 100);
    RREADY <= 1'b0;
    if (n >= 100) failures++;
    @(posedge CLK);
  endtask
  task automatic setr(input logic [7:0] i, input logic [7:0] v);
    wr(4'h0, {24'h0, i});
    wr(4'h4, {24'h0, v});
  endtask
  task automatic getr(input logic [7:0] i, input logic [31:0] e, input logic [31:0] m);
    wr(4'h0, {24'h0, i});
    rd(4'h4, e, m, 2'h0);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Takes the oldest note off the queue at each read answer.
  always @(posedge CLK) begin
    if (RVALID && RREADY && notes.size() > 0) begin
      cmp_bus("rdata", notes[0].e & notes[0].m, RDATA & notes[0].m);
      cmp_bus("rresp", {30'h0, notes[0].r}, {30'h0, RRESP});
      void'(notes.pop_front());
    end
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    {RST, SUSPEND, LINE_TICK, s1, s2, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 10'h260;
    {AWADDR, ARADDR, WDATA, btn} = {40'h0, 6'h3F};
    void'($urandom(32'h641175AD));
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    cmp_pin("oe", 6'h38, MISC_OE);
    cmp_pin("out", 6'h18, MISC_OUT);
    foreach (didx[k]) getr(didx[k], {24'h0, dval[k]}, 32'hFFFFFF3F);
    // Unmasked pin 1 fall raises the interrupt; reads clear it.
    rd(4'h8, 32'h0, 32'h0, 2'h0);
    wr(4'hC, 32'h4);
    btn <= 6'h3E;
    repeat (5) @(posedge CLK);
    cmp_pin("irq", 6'h01, {5'h0, IRQ});
    rd(4'h8, 32'h4, 32'hFFFFFFFF, 2'h0);
    cmp_pin("irq", 6'h00, {5'h0, IRQ});
    wr(4'h0, 32'h2);
    rd(4'h4, 32'h4, 32'hFFFFFF1F, 2'h0);
    rd(4'h4, 32'h0, 32'hFFFFFF1F, 2'h0);
    wr(4'hC, 32'h0);
    btn <= 6'h3C;
    repeat (5) @(posedge CLK);
    cmp_pin("irq", 6'h00, {5'h0, IRQ});
    // Random outputs survive a soft reset, not a suspend.
    r = 6'($urandom);
    setr(8'h08, 8'h3F);
    setr(8'h0B, {2'h0, r});
    setr(8'h07, 8'h80);
    cmp_pin("oe", 6'h3F, MISC_OE);
    cmp_pin("out", r, MISC_OUT);
    SUSPEND <= 1'b1;
    repeat (3) @(posedge CLK);
    SUSPEND <= 1'b0;
    @(posedge CLK);
    cmp_pin("oe", 6'h38, MISC_OE);
    cmp_pin("out", 6'h18, MISC_OUT);
    // Level mode, active high, random levels.
    setr(8'h08, 8'h00);
    setr(8'h09, 8'h3F);
    setr(8'h0A, 8'h00);
    r = 6'($urandom);
    btn <= r;
    repeat (5) @(posedge CLK);
    getr(8'h02, {24'h0, r, 2'h0}, 32'hFFFFFFFF);
    // Sense one stops a scan; sense two stops forward motion after two lines but not reverse.
    s1 <= 1'b0;
    s2 <= 1'b0;
    setr(8'h03, 8'h7F);
    getr(8'h03, 32'h6F, 32'hFFFFFFFF);
    setr(8'h07, 8'h01);
    cmp_pin("scan", 6'h01, {5'h0, SCANNING});
    s1 <= 1'b1;
    repeat (6) @(posedge CLK);
    cmp_pin("scan", 6'h00, {5'h0, SCANNING});
    setr(8'h07, 8'h03);
    s2 <= 1'b1;
    repeat (6) @(posedge CLK);
    cmp_pin("scan", 6'h01, {5'h0, SCANNING});
    s2 <= 1'b0;
    setr(8'h07, 8'h00);
    setr(8'h0C, 8'h02);
    setr(8'h07, 8'h02);
    s2 <= 1'b1;
    repeat (4) @(posedge CLK);
    repeat (2) begin
      LINE_TICK <= 1'b1;
      @(posedge CLK);
      LINE_TICK <= 1'b0;
      @(posedge CLK);
    end
    repeat (6) @(posedge CLK);
    cmp_pin("scan", 6'h00, {5'h0, SCANNING});
    getr(8'h02, 32'h3, 32'h3);
    rd(4'h2, 32'h0, 32'hFFFFFFFF, 2'h3);
    // A hard reset pulse in mid-run brings the pin defaults back.
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    cmp_pin("oe", 6'h38, MISC_OE);
    cmp_pin("out", 6'h18, MISC_OUT);
    give_verdict();
  end
endmodule // sgio_port_bench
